// ### hw/clk_rst_pkg.sv
// Package of constants and carriers for the bus clock and reset controller
package clk_rst_pkg;
  // Register offsets
  localparam logic [15:0] BREAK_STATE_OFS = 16'hfe00;
  localparam logic [15:0] RESET_CAUSE_OFS = 16'hfe01;
  localparam logic [15:0] BREAK_CTL_OFS = 16'hfe03;
  localparam logic [15:0] IRQ_STAT_OFS = 16'hfe04;
  localparam logic [15:0] IRQ_MASK_OFS = 16'hfe05;
  localparam logic [15:0] CTRL_OFS = 16'hfe06;
  localparam logic [15:0] VECTOR_OFS = 16'hfe07;
  // Field positions
  localparam int RC_POWER_BIT = 7;
  localparam int RC_PIN_BIT = 6;
  localparam int RC_WDOG_BIT = 5;
  localparam int RC_OPC_BIT = 4;
  localparam int RC_ADDR_BIT = 3;
  localparam int RC_BROWN_BIT = 1;
  localparam int BS_WAIT_BIT = 1;
  localparam int CTRL_QUICK_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CTRL_WAIT_BIT = 2;
  localparam int EV_CLK_RUN_BIT = 0;
  localparam int EV_IRQ_BIT = 1;
  localparam int EV_WAKE_BIT = 2;
  // Reset values
  localparam logic [7:0] RESET_CAUSE_RST = 8'h80;
  localparam logic [7:0] BREAK_CTL_RST = 8'h80;
  localparam logic [7:0] BREAK_STATE_RST = 8'h00;
  localparam logic [7:0] RC_VALID_MASK = 8'hfa;
  // Timing: delays in reference clock cycles, bus divider in generator clock cycles
  localparam logic [11:0] LONG_DELAY_M1 = 12'hfff;
  localparam logic [11:0] SHORT_DELAY_M1 = 12'h01f;
  localparam logic [1:0] BUS_DIV_M1 = 2'h3;
  localparam int NUM_IRQ = 24;
  localparam int VEC_W = 5;
  localparam logic [VEC_W-1:0] NO_VECTOR = 5'h1f;

  typedef struct packed {
    logic power;
    logic brownout;
    logic pin;
    logic watchdog;
    logic bad_opcode;
    logic bad_fetch_address;
  } reset_src_s;

  typedef struct packed {
    logic cpu_clk_en;
    logic periph_clk_en;
    logic bus_tick;
  } clk_out_s;

  typedef enum logic [1:0] {ST_STARTUP, ST_RUN, ST_STOP, ST_RECOVER} pwr_state_e;
endpackage

// ### hw/system_bus_clock_and_reset_ctl.sv
// Bus clock gating, start-up delay, reset causes and interrupt arbitration
`timescale 1ns/1ps

// Summary of operation
// - Bus rate is selected source over four
// - Bus tick is generator output over four
// - Hold clocks 4096 reference cycles after power
// - Drive reset line low during start-up
// - Start bus clocks after start-up timeout
// - Reference clock runs counter on stop exit
// - Hold clocks for stop delay after wake
// - Wait mode stops CPU clocks, and peripheral clocks unless periph_wait_active
// - Read-only reset cause register layout
// - Break status holds break-wait flag bit1
// - Arbitrate 24 interrupts, produce winning vector
// - Twelve-bit counter on reference falling edge
// - Quick wake selects 32, else 4096
// - Power-on sets power flag, clears others
module system_bus_clock_and_reset_ctl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Clock generator outputs, asynchronous to clk
  input wire logic osc_ref_clock,
  input wire logic clock_gen_output,
  // Reset sources
  input wire clk_rst_pkg::reset_src_s reset_src,
  // Stop wake events, break and wait-mode peripheral hold
  input wire logic wake_event,
  input wire logic break_wait,
  input wire logic periph_wait_active,
  // Interrupt sources, same clock
  input wire logic [clk_rst_pkg::NUM_IRQ-1:0] irq_src,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Outputs to core
  output clk_rst_pkg::clk_out_s clk_out,
  output logic ext_reset_o,
  output logic ext_reset_oe_b,
  output logic internal_reset,
  output logic [clk_rst_pkg::VEC_W-1:0] irq_vector,
  output logic irq_pending,
  output logic irq
);

  logic [1:0] ref_sync_q;
  logic ref_last_q;
  logic [1:0] gen_sync_q;
  logic gen_last_q;
  logic ref_fall;
  logic gen_rise;
  logic [11:0] su_count_q;
  logic [11:0] delay_target;
  logic [1:0] bus_div_q;
  clk_rst_pkg::pwr_state_e state_q;
  logic [7:0] reset_cause_q;
  logic [7:0] break_state_q;
  logic [7:0] ctrl_q;
  logic [7:0] irq_stat_q;
  logic [7:0] irq_mask_q;
  logic [7:0] ev_set;
  logic clocks_run;
  logic clocks_run_q;
  logic [clk_rst_pkg::VEC_W-1:0] win_vec;
  logic win_any;
  logic [11:0] startup_hits;
  logic cold_start;

  // Both generator clocks are foreign; sync before edge detection
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ref_sync_q <= 2'h0;
      ref_last_q <= 1'b0;
      gen_sync_q <= 2'h0;
      gen_last_q <= 1'b0;
    end
    else
    begin
      ref_sync_q <= {ref_sync_q[0], osc_ref_clock};
      ref_last_q <= ref_sync_q[1];
      gen_sync_q <= {gen_sync_q[0], clock_gen_output};
      gen_last_q <= gen_sync_q[1];
    end
  end

  assign ref_fall = ref_last_q & ~ref_sync_q[1];
  assign gen_rise = ~gen_last_q & gen_sync_q[1];

  // Each generator rising edge is one bus phase; four phases per bus cycle
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      bus_div_q <= 2'h0;
    else if (gen_rise && clocks_run)
      bus_div_q <= bus_div_q + 2'h1;
  end

  // Startup delay length; quick wake only shortens stop recovery
  always_comb
  begin
    if (state_q == clk_rst_pkg::ST_RECOVER && ctrl_q[clk_rst_pkg::CTRL_QUICK_BIT])
      delay_target = clk_rst_pkg::SHORT_DELAY_M1;
    else
      delay_target = clk_rst_pkg::LONG_DELAY_M1;
  end

  assign cold_start = reset_src.power | reset_src.brownout;
  assign startup_hits = su_count_q;

  // Power state sequencing
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_q <= clk_rst_pkg::ST_STARTUP;
      su_count_q <= 12'h000;
    end
    else if (cold_start)
    begin
      state_q <= clk_rst_pkg::ST_STARTUP;
      su_count_q <= 12'h000;
    end
    else
    begin
      unique case (state_q)
        clk_rst_pkg::ST_STARTUP, clk_rst_pkg::ST_RECOVER:
        begin
          if (ref_fall)
          begin
            if (startup_hits == delay_target)
            begin
              state_q <= clk_rst_pkg::ST_RUN;
              su_count_q <= 12'h000;
            end
            else
              su_count_q <= su_count_q + 12'h001;
          end
        end
        clk_rst_pkg::ST_RUN:
        begin
          if (ctrl_q[clk_rst_pkg::CTRL_STOP_BIT])
          begin
            state_q <= clk_rst_pkg::ST_STOP;
            su_count_q <= 12'h000;
          end
        end
        clk_rst_pkg::ST_STOP:
        begin
          if (wake_event || win_any || break_wait)
            state_q <= clk_rst_pkg::ST_RECOVER;
        end
      endcase
    end
  end

  assign clocks_run = (state_q == clk_rst_pkg::ST_RUN);

  // Clocks held in inactive phase until released
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      clk_out <= '0;
      clocks_run_q <= 1'b0;
    end
    else
    begin
      clocks_run_q <= clocks_run;
      clk_out.bus_tick <= clocks_run && gen_rise && (bus_div_q == clk_rst_pkg::BUS_DIV_M1);
      clk_out.cpu_clk_en <= clocks_run && !ctrl_q[clk_rst_pkg::CTRL_WAIT_BIT];
      clk_out.periph_clk_en <= clocks_run &&
        (!ctrl_q[clk_rst_pkg::CTRL_WAIT_BIT] || periph_wait_active);
    end
  end

  // External reset line is open drain: drive low during cold start-up
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ext_reset_o <= 1'b0;
      ext_reset_oe_b <= 1'b0;
      internal_reset <= 1'b1;
    end
    else
    begin
      ext_reset_o <= 1'b0;
      ext_reset_oe_b <= !(state_q == clk_rst_pkg::ST_STARTUP);
      internal_reset <= (state_q == clk_rst_pkg::ST_STARTUP);
    end
  end

  // Reset cause flags; power-on wipes every other cause
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      reset_cause_q <= clk_rst_pkg::RESET_CAUSE_RST;
    else if (reset_src.power)
      reset_cause_q <= clk_rst_pkg::RESET_CAUSE_RST;
    else
    begin
      if (reset_src.pin)
        reset_cause_q[clk_rst_pkg::RC_PIN_BIT] <= 1'b1;
      if (reset_src.watchdog)
        reset_cause_q[clk_rst_pkg::RC_WDOG_BIT] <= 1'b1;
      if (reset_src.bad_opcode)
        reset_cause_q[clk_rst_pkg::RC_OPC_BIT] <= 1'b1;
      if (reset_src.bad_fetch_address)
        reset_cause_q[clk_rst_pkg::RC_ADDR_BIT] <= 1'b1;
      if (reset_src.brownout)
        reset_cause_q[clk_rst_pkg::RC_BROWN_BIT] <= 1'b1;
    end
  end

  // Break-wait flag; only bit 1 exists, set wins over a write
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      break_state_q <= clk_rst_pkg::BREAK_STATE_RST;
    else if (break_wait)
      break_state_q[clk_rst_pkg::BS_WAIT_BIT] <= 1'b1;
    else if (reg_wr && reg_addr == clk_rst_pkg::BREAK_STATE_OFS)
      break_state_q[clk_rst_pkg::BS_WAIT_BIT] <= reg_wdata[clk_rst_pkg::BS_WAIT_BIT];
  end

  // Control and interrupt mask registers
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      ctrl_q <= 8'h00;
      irq_mask_q <= 8'h00;
    end
    else if (reg_wr)
    begin
      if (reg_addr == clk_rst_pkg::CTRL_OFS)
        ctrl_q <= reg_wdata;
      else if (reg_addr == clk_rst_pkg::IRQ_MASK_OFS)
        irq_mask_q <= reg_wdata;
    end
    else if (!clocks_run && state_q == clk_rst_pkg::ST_RECOVER)
      ctrl_q[clk_rst_pkg::CTRL_STOP_BIT] <= 1'b0;
    else if (win_any && ctrl_q[clk_rst_pkg::CTRL_WAIT_BIT])
      ctrl_q[clk_rst_pkg::CTRL_WAIT_BIT] <= 1'b0;
  end

  // Priority arbiter: lowest source index wins
  always_comb
  begin
    win_vec = clk_rst_pkg::NO_VECTOR;
    win_any = 1'b0;
    for (int i = clk_rst_pkg::NUM_IRQ - 1; i >= 0; i--)
    begin
      if (irq_src[i])
      begin
        win_vec = clk_rst_pkg::VEC_W'(i);
        win_any = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      irq_vector <= clk_rst_pkg::NO_VECTOR;
      irq_pending <= 1'b0;
    end
    else
    begin
      irq_vector <= win_vec;
      irq_pending <= win_any;
    end
  end

  // Sticky events; set wins over the read clear
  always_comb
  begin
    ev_set = 8'h00;
    ev_set[clk_rst_pkg::EV_CLK_RUN_BIT] = clocks_run & ~clocks_run_q;
    ev_set[clk_rst_pkg::EV_IRQ_BIT] = win_any;
    ev_set[clk_rst_pkg::EV_WAKE_BIT] = (state_q == clk_rst_pkg::ST_STOP) & wake_event;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
      irq_stat_q <= 8'h00;
    else if (reg_rd && reg_addr == clk_rst_pkg::IRQ_STAT_OFS)
      irq_stat_q <= ev_set;
    else
      irq_stat_q <= irq_stat_q | ev_set;
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        clk_rst_pkg::BREAK_STATE_OFS: reg_rdata <= break_state_q;
        clk_rst_pkg::RESET_CAUSE_OFS: reg_rdata <= reset_cause_q & clk_rst_pkg::RC_VALID_MASK;
        clk_rst_pkg::BREAK_CTL_OFS: reg_rdata <= clk_rst_pkg::BREAK_CTL_RST;
        clk_rst_pkg::IRQ_STAT_OFS: reg_rdata <= irq_stat_q;
        clk_rst_pkg::IRQ_MASK_OFS: reg_rdata <= irq_mask_q;
        clk_rst_pkg::CTRL_OFS: reg_rdata <= ctrl_q;
        clk_rst_pkg::VECTOR_OFS: reg_rdata <= {3'h0, irq_vector};
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

endmodule

// ### dv/clk_rst_props.sv
// Concurrent checks on the bus clock and reset controller ports
`timescale 1ns/1ps
module clk_rst_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Observed ports
  input wire logic [clk_rst_pkg::NUM_IRQ-1:0] irq_src,
  input wire logic [15:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire clk_rst_pkg::clk_out_s clk_out,
  input wire logic ext_reset_o,
  input wire logic ext_reset_oe_b,
  input wire logic internal_reset,
  input wire logic [clk_rst_pkg::VEC_W-1:0] irq_vector
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data seen outside the answer cycle");
  a_cause_layout: assert property (
    reg_rd && reg_addr == 16'hfe01 |=> (reg_rdata & 8'h05) == 8'h00)
    else $error("reset cause bits 2 or 0 read as one");
  a_break_layout: assert property (
    reg_rd && reg_addr == 16'hfe00 |=> (reg_rdata & 8'hfd) == 8'h00)
    else $error("break state reserved bit read as one");
  a_ctl_const: assert property (reg_rd && reg_addr == 16'hfe03 |=> reg_rdata == 8'h80)
    else $error("break flag control not constant");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 16'hfe02 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_start_hold: assert property (
    internal_reset |-> !ext_reset_oe_b && !clk_out.cpu_clk_en && !clk_out.periph_clk_en)
    else $error("clocks or reset line wrong during start-up");
  a_pin_low: assert property (ext_reset_o == 1'b0)
    else $error("reset line data not low");
  a_start_release: assert property (
    $fell(internal_reset) |-> ##[0:2] clk_out.cpu_clk_en)
    else $error("clocks not started after start-up");
  a_tick_pulse: assert property (clk_out.bus_tick |=> !clk_out.bus_tick)
    else $error("bus tick longer than one cycle");
  a_irq_win: assert property (
    irq_src[2:0] == 3'b100 [*3] |-> irq_vector == 5'h02)
    else $error("wrong winning interrupt vector");
endmodule

bind system_bus_clock_and_reset_ctl clk_rst_props i_clk_rst_props (
  .clk(clk), .rst_b(rst_b), .irq_src(irq_src), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .clk_out(clk_out), .ext_reset_o(ext_reset_o),
  .ext_reset_oe_b(ext_reset_oe_b), .internal_reset(internal_reset), .irq_vector(irq_vector)
);

// ### dv/clk_gen_model.sv
// Free-running reference and generator clocks standing in for the clock source
`timescale 1ns/1ps
module clk_gen_model #(
  parameter real REF_HALF = 10.0,
  parameter real GEN_HALF = 12.0
) (
  // Clocks to the controller
  output logic osc_ref_clock,
  output logic clock_gen_output
);
  // Reference keeps running in stop, so recovery can count it
  initial
  begin
    osc_ref_clock = 1'b1;
    #3;
    forever #(REF_HALF) osc_ref_clock = ~osc_ref_clock;
  end
  // Slower than four bus clocks so the synchroniser sees every edge
  initial
  begin
    clock_gen_output = 1'b0;
    forever #(GEN_HALF) clock_gen_output = ~clock_gen_output;
  end
endmodule

// ### dv/system_bus_clock_and_reset_ctl_tb_top.sv
// Self-checking bench for the bus clock and reset controller
`timescale 1ns/1ps
module system_bus_clock_and_reset_ctl_tb_top;
  logic clk, rst_b, osc_ref_clock, clock_gen_output, wake_event, break_wait, periph_wait_active;
  logic reg_wr, reg_rd, ext_reset_o, ext_reset_oe_b, internal_reset, irq_pending, irq;
  clk_rst_pkg::reset_src_s reset_src;
  clk_rst_pkg::clk_out_s clk_out;
  logic [23:0] irq_src;
  logic [15:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [4:0] irq_vector;
  int num_errors = 0, n_checks = 0, ticks = 0, t0;
  // Row: op (1 write, 0 read), address, write data or expected read
  logic [31:0] rows [8] = '{32'h00fe0000, 32'h00fe0180, 32'h00fe0380, 32'h00fe0200,
                            32'h01fe01ff, 32'h00fe0180, 32'h00fe0500, 32'h00fe0600};

  clk_gen_model i_clk_gen_model (.osc_ref_clock(osc_ref_clock),
    .clock_gen_output(clock_gen_output));
  system_bus_clock_and_reset_ctl i_system_bus_clock_and_reset_ctl (.clk(clk), .rst_b(rst_b),
    .osc_ref_clock(osc_ref_clock), .clock_gen_output(clock_gen_output), .reset_src(reset_src),
    .wake_event(wake_event), .break_wait(break_wait), .periph_wait_active(periph_wait_active),
    .irq_src(irq_src), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .clk_out(clk_out), .ext_reset_o(ext_reset_o),
    .ext_reset_oe_b(ext_reset_oe_b), .internal_reset(internal_reset),
    .irq_vector(irq_vector), .irq_pending(irq_pending), .irq(irq));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (clk_out.bus_tick === 1'b1) ticks++;

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 cmp({8'h00, reg_rdata}, {8'h00, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Clocks held for n reference cycles; slack covers the synchroniser
  task automatic span(input int n);
    repeat (n - 6) @(negedge osc_ref_clock);
    #1 cmp({clk_out.cpu_clk_en, clk_out.periph_clk_en}, 16'h0);
    repeat (12) @(negedge osc_ref_clock);
    #1 cmp({clk_out.cpu_clk_en, clk_out.periph_clk_en}, 16'h3);
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic pulse_src(input clk_rst_pkg::reset_src_s s);
    @(posedge clk);
    reset_src <= s;
    repeat (2) @(posedge clk);
    reset_src <= '0;
  endtask

  initial
  begin
    rst_b = 1'b0;
    {reset_src, wake_event, break_wait, periph_wait_active, irq_src} = '0;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    tick(1);
    cmp({internal_reset, ext_reset_oe_b, ext_reset_o}, 16'h4);
    span(4096);
    cmp({internal_reset, ext_reset_oe_b}, 16'h1);
    done("startup");
    foreach (rows[i])
      if (rows[i][24])
        wr(rows[i][23:8], rows[i][7:0]);
      else
        rd(rows[i][23:8], rows[i][7:0]);
    done("registers");
    t0 = ticks;
    repeat (40) @(posedge clock_gen_output);
    cmp({15'h0, (ticks - t0) >= 9 && (ticks - t0) <= 11}, 16'h1);
    done("bus rate");
    cmp({15'h0, irq}, 16'h0);
    wr(16'hfe05, 8'h01);
    tick(1);
    cmp({15'h0, irq}, 16'h1);
    rd(16'hfe04, 8'h01);
    tick(1);
    cmp({15'h0, irq}, 16'h0);
    rd(16'hfe04, 8'h00);
    done("interrupt");
    @(posedge clk);
    periph_wait_active <= 1'b1;
    wr(16'hfe06, 8'h04);
    tick(3);
    cmp({clk_out.cpu_clk_en, clk_out.periph_clk_en}, 16'h1);
    @(posedge clk);
    periph_wait_active <= 1'b0;
    tick(2);
    cmp({clk_out.cpu_clk_en, clk_out.periph_clk_en}, 16'h0);
    @(posedge clk);
    irq_src <= 24'h000104;
    tick(4);
    cmp({irq_vector, irq_pending, clk_out.cpu_clk_en}, 16'h0b);
    rd(16'hfe07, 8'h02);
    @(posedge clk);
    irq_src <= '0;
    tick(1);
    cmp({15'h0, irq}, 16'h0);
    rd(16'hfe04, 8'h02);
    rd(16'hfe06, 8'h00);
    done("wait");
    wr(16'hfe06, 8'h03);
    tick(3);
    cmp({13'h0, clk_out}, 16'h0);
    @(posedge clk);
    wake_event <= 1'b1;
    @(posedge clk);
    wake_event <= 1'b0;
    span(32);
    // Wake and clock restart both leave sticky events
    rd(16'hfe04, 8'h05);
    rd(16'hfe06, 8'h01);
    wr(16'hfe06, 8'h02);
    tick(3);
    @(posedge clk);
    break_wait <= 1'b1;
    @(posedge clk);
    break_wait <= 1'b0;
    span(4096);
    rd(16'hfe00, 8'h02);
    done("stop");
    pulse_src('{watchdog: 1'b1, default: 1'b0});
    rd(16'hfe01, 8'ha0);
    pulse_src('{power: 1'b1, default: 1'b0});
    rd(16'hfe01, 8'h80);
    cmp({internal_reset, ext_reset_oe_b}, 16'h2);
    pulse_src('{brownout: 1'b1, default: 1'b0});
    rd(16'hfe01, 8'h82);
    pulse_src('{pin: 1'b1, bad_opcode: 1'b1, bad_fetch_address: 1'b1, default: 1'b0});
    rd(16'hfe01, 8'hda);
    done("reset causes");
    results();
  end
  // Run needs about 166 us; far beyond that means a hang
  initial
  begin
    #300000;
    num_errors++;
    results();
  end
endmodule
